// ---- hw/otp_program_sequencer.sv ----
// sequencer for burning and reloading the nonvolatile configuration image
// Functional notes
// - image is registers 0x07 to 0x15, staged by host before burn
// - writing 0xA5 to 0x78 starts burning the staged image
// - after 20ms host reads fail flag; zero success, one failure, retry
// - writing 0x5A to 0x79 reloads working registers from memory
// - control bit 6 suppresses autorefresh while programming runs
// - memory accepts at most six programming operations
`timescale 1ns/1ps
`default_nettype none
module otp_program_sequencer #(
   parameter int BURN_CYCLES_P = nv_seq_pkg::BURN_CYCLES,
   parameter int IMAGE_BYTES   = 15
) (
   input  wire logic                     mclk,
   input  wire logic                     srst,
   input  wire logic                     wr_strobe,
   input  wire logic [7:0]               wr_addr,
   input  wire logic [7:0]               wr_data,
   input  wire logic                     refresh_inhibit,
   input  wire logic                     refresh_request,
   input  wire logic                     program_supply_ok,
   input  wire logic [IMAGE_BYTES*8-1:0] image_staged,
   input  wire logic [IMAGE_BYTES*8-1:0] nv_contents,
   input  wire logic                     nv_write_ok,
   output logic                          nv_write_en,
   output logic [IMAGE_BYTES*8-1:0]      nv_write_data,
   output logic                          reload_en,
   output logic [IMAGE_BYTES*8-1:0]      reload_data,
   output logic                          refresh_allow,
   output logic                          program_fail_flag,
   output logic                          busy,
   output logic [2:0]                    program_count
);
   // ----------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------
   localparam int IMAGE_SPAN = int'(nv_seq_pkg::NV_IMAGE_LAST_ADDR) - int'(nv_seq_pkg::NV_IMAGE_FIRST_ADDR) + 1;

   // the image must cover exactly the staged register span
   if (IMAGE_BYTES != IMAGE_SPAN) begin : g_bad_image
      $error("image width does not match the staged register span");
   end
   // the countdown needs two cycles to sample the result
   if (BURN_CYCLES_P < 2) begin : g_bad_burn
      $error("burn length below two cycles");
   end

   // ----------------------------------------------------------
   // supply pin synchroniser
   // ----------------------------------------------------------
   logic sup_meta_reg, sup_reg;
   always_ff @(posedge mclk) begin
      if (srst) begin
         sup_meta_reg <= 1'b0;
         sup_reg      <= 1'b0;
      end else begin
         sup_meta_reg <= program_supply_ok;
         sup_reg      <= sup_meta_reg;
      end
   end

   // ----------------------------------------------------------
   // command decode
   // ----------------------------------------------------------
   // true when a register write hits a command address with its key
   function automatic logic cmd_hit(
      input logic       strobe,
      input logic [7:0] addr,
      input logic [7:0] data,
      input logic [7:0] cmd_addr,
      input logic [7:0] cmd_key
   );
      return strobe && (addr == cmd_addr) && (data == cmd_key);
   endfunction

   logic burn_cmd;
   logic reload_cmd;

   assign burn_cmd   = cmd_hit(wr_strobe, wr_addr, wr_data, nv_seq_pkg::NV_BURN_ADDR, nv_seq_pkg::NV_BURN_KEY);
   // reload key decode; other values match neither
   assign reload_cmd = cmd_hit(wr_strobe, wr_addr, wr_data, nv_seq_pkg::NV_RELOAD_ADDR, nv_seq_pkg::NV_RELOAD_KEY);

   // ----------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------
   typedef enum logic [1:0] {IDLE, BURN, RELOAD} seq_e;
   seq_e                     state_reg, state_next;
   logic [31:0]              cnt_reg, cnt_next;
   logic                     fail_reg, fail_next;
   logic [2:0]               count_reg, count_next;
   logic [IMAGE_BYTES*8-1:0] data_reg, data_next;
   logic                     wen_reg, wen_next;
   logic                     ren_reg, ren_next;
   logic [IMAGE_BYTES*8-1:0] rdata_reg, rdata_next;

   // ----------------------------------------------------------
   // sequencer events
   // ----------------------------------------------------------
   logic burn_refused;
   logic burn_start;
   logic burn_last;
   logic burn_bad;
   logic reload_last;

   always_comb begin
      burn_refused = 1'b0;
      burn_start   = 1'b0;
      if (state_reg == IDLE && burn_cmd) begin
         if (count_reg >= 3'(nv_seq_pkg::NV_MAX_PROGRAMS) || !sup_reg) begin
            burn_refused = 1'b1;
         end else begin
            burn_start = 1'b1;
         end
      end
   end

   assign burn_last   = (state_reg == BURN) && (cnt_reg == 32'd0);
   assign reload_last = (state_reg == RELOAD) && (cnt_reg == 32'd0);
   // failure when the array refuses or reads back wrong
   assign burn_bad    = !nv_write_ok || (nv_contents != data_reg);

   // ----------------------------------------------------------
   // sequencer next state
   // ----------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      fail_next  = fail_reg;
      count_next = count_reg;
      data_next  = data_reg;
      wen_next   = 1'b0;
      ren_next   = 1'b0;
      rdata_next = rdata_reg;
      case (state_reg)
         IDLE: begin
            if (burn_refused) begin
               fail_next = 1'b1;
            end else if (burn_start) begin
               data_next  = image_staged;
               wen_next   = 1'b1;
               count_next = count_reg + 3'd1;
               fail_next  = 1'b0;
               cnt_next   = 32'(BURN_CYCLES_P - 1);
               state_next = BURN;
            end else if (reload_cmd) begin
               cnt_next   = 32'(nv_seq_pkg::RELOAD_CYCLES - 1);
               state_next = RELOAD;
            end
         end
         BURN: begin
            if (burn_last) begin
               fail_next  = burn_bad;
               state_next = IDLE;
            end else begin
               // write enable drops together with busy
               wen_next = 1'b1;
               cnt_next = cnt_reg - 32'd1;
            end
         end
         RELOAD: begin
            if (reload_last) begin
               rdata_next = nv_contents;
               ren_next   = 1'b1;
               state_next = IDLE;
            end else begin
               cnt_next = cnt_reg - 32'd1;
            end
         end
         default: begin
            state_next = IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------
   // state registers
   // ----------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= IDLE;
         cnt_reg   <= 32'd0;
         fail_reg  <= 1'b0;
         count_reg <= 3'd0;
         data_reg  <= '0;
         wen_reg   <= 1'b0;
         ren_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         fail_reg  <= fail_next;
         count_reg <= count_next;
         data_reg  <= data_next;
         wen_reg   <= wen_next;
         ren_reg   <= ren_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign nv_write_en       = wen_reg;
   assign nv_write_data     = data_reg;
   assign reload_en         = ren_reg;
   assign reload_data       = rdata_reg;
   assign program_fail_flag = fail_reg;
   assign busy              = state_reg != IDLE;
   assign program_count     = count_reg;
   assign refresh_allow     = refresh_request && !(refresh_inhibit && state_reg == BURN);
endmodule
`default_nettype wire

// ---- hw/nv_seq_pkg.sv ----
// constants for the nonvolatile program sequencer
package nv_seq_pkg;
   localparam logic [7:0] NV_IMAGE_FIRST_ADDR  = 8'h07;
   localparam logic [7:0] NV_IMAGE_LAST_ADDR   = 8'h15;
   localparam logic [7:0] NV_BURN_ADDR         = 8'h78;
   localparam logic [7:0] NV_RELOAD_ADDR       = 8'h79;
   localparam logic [7:0] NV_BURN_KEY          = 8'hA5;
   localparam logic [7:0] NV_RELOAD_KEY        = 8'h5A;
   localparam int         CTRL_INHIBIT_BIT     = 6;
   localparam int         NV_MAX_PROGRAMS      = 6;
   localparam int         CLK_HZ               = 40000000;
   localparam int         BURN_TIME_US         = 20000;
   localparam int         BURN_CYCLES          = (BURN_TIME_US * (CLK_HZ / 1000000));
   localparam int         RELOAD_CYCLES        = 32;
endpackage

// ---- sim/nv_seq_monitor.sv ----
// assertion checker for the nonvolatile program sequencer
`timescale 1ns/1ps
`default_nettype none
module nv_seq_monitor #(
   parameter int BURN_LEN = nv_seq_pkg::BURN_CYCLES
) (
   input wire logic       mclk,
   input wire logic       srst,
   input wire logic       wr_strobe,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic       refresh_inhibit,
   input wire logic       refresh_request,
   input wire logic       program_supply_ok,
   input wire logic       nv_write_ok,
   input wire logic       nv_write_en,
   input wire logic       reload_en,
   input wire logic       refresh_allow,
   input wire logic       program_fail_flag,
   input wire logic       busy,
   input wire logic [2:0] program_count
);
   localparam logic [7:0] BA = nv_seq_pkg::NV_BURN_ADDR;
   localparam logic [7:0] BK = nv_seq_pkg::NV_BURN_KEY;
   logic                  sup_meta_reg;
   logic                  sup_reg;
   int unsigned           wen_run_reg;
   // supply pin as the block sees it, two clocks late; length of the write run
   always_ff @(posedge mclk) begin
      sup_meta_reg <= !srst && program_supply_ok;
      sup_reg      <= !srst && sup_meta_reg;
      wen_run_reg  <= (srst || !nv_write_en) ? 0 : wen_run_reg + 1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_cmd(a, d);
      wr_strobe && !busy && wr_addr == a && wr_data == d;
   endsequence
   sequence s_go;
      s_cmd(BA, BK) ##0 (sup_reg && program_count < 3'h6);
   endsequence
   sequence s_refused;
      s_cmd(BA, BK) ##0 (!sup_reg || program_count >= 3'h6);
   endsequence
   AST_BURN_START: assert property (s_go |=> busy && nv_write_en && !program_fail_flag)
      else $error("burn did not start");
   AST_BURN_LEN: assert property ($fell(nv_write_en) && !$past(srst) |-> wen_run_reg == BURN_LEN)
      else $error("burn length wrong");
   AST_COUNT_INC: assert property (s_go |=> program_count == $past(program_count) + 3'h1)
      else $error("count not advanced");
   AST_REFUSED: assert property (s_refused |=> !nv_write_en && program_fail_flag)
      else $error("refused burn not flagged");
   AST_COUNT_MAX: assert property (program_count <= 3'h6)
      else $error("count above limit");
   AST_BAD_KEY: assert property (wr_strobe && !busy && wr_addr == BA && wr_data != BK |=> !nv_write_en)
      else $error("wrong key started burn");
   AST_RELOAD: assert property (s_cmd(nv_seq_pkg::NV_RELOAD_ADDR, nv_seq_pkg::NV_RELOAD_KEY) |-> ##33 reload_en)
      else $error("reload pulse missing");
   AST_REFRESH: assert property (refresh_allow == (refresh_request && !(refresh_inhibit && nv_write_en)))
      else $error("refresh gating wrong");
   AST_RESULT: assert property ($fell(nv_write_en) && !nv_write_ok |-> program_fail_flag)
      else $error("failed write not flagged");
endmodule
bind otp_program_sequencer nv_seq_monitor #(.BURN_LEN(BURN_CYCLES_P)) u_mon (.*);
`default_nettype wire

// ---- sim/nv_array_model.sv ----
// behavioural model of the nonvolatile array
`timescale 1ns/1ps
`default_nettype none
module nv_array_model (
   input wire logic           mclk,
   input wire logic           nv_write_en,
   input wire logic           fail_mode,
   input wire logic [119:0]   nv_write_data,
   output var logic [119:0]   nv_contents,
   output logic               nv_write_ok
);
   assign nv_write_ok = !fail_mode;
   initial nv_contents = '0;
   always @(posedge mclk) if (nv_write_en) nv_contents <= fail_mode ? ~nv_write_data : nv_write_data;
endmodule
`default_nettype wire

// ---- sim/otp_program_sequencer_tb.sv ----
// self-checking testbench for the nonvolatile program sequencer
`timescale 1ns/1ps
`default_nettype none
module otp_program_sequencer_tb;
   logic mclk = 0, srst = 1, wr_strobe = 0, refresh_inhibit = 1, refresh_request = 1, program_supply_ok = 1;
   logic fail_mode = 0, nv_write_ok, nv_write_en, reload_en, refresh_allow, program_fail_flag, busy, seen;
   logic [7:0] wr_addr = '0, wr_data = '0;
   logic [2:0] program_count;
   // staged image has even overall parity
   logic [119:0] image_staged = 120'h15_1413_1211_100f_0e0d_0c0b_0a09_0807, nv_contents, nv_write_data, reload_data;
   int failures = 0, checks_done = 0;
   always #12.5 mclk = ~mclk;
   otp_program_sequencer #(.BURN_CYCLES_P(8)) dut (.*);
   nv_array_model u_nv (.*);
   task chk(input logic [119:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, d);
      @(posedge mclk); wr_strobe <= 1; wr_addr <= a; wr_data <= d;
      @(posedge mclk); wr_strobe <= 0;
   endtask
   task burn(input logic f, input logic [2:0] n);
      fail_mode <= f;
      wr(8'h78, 8'ha5);
      @(posedge mclk) #1 chk({busy, nv_write_en, refresh_allow}, {2'b11, !refresh_inhibit});
      chk(nv_write_data, image_staged);
      repeat (8) @(posedge mclk);
      #1 chk({busy, nv_write_en, program_fail_flag, program_count, refresh_allow}, {2'b00, f, n, 1'b1});
   endtask
   task t_bad_keys;
      seen = 0;
      wr(8'h78, 8'h5a);
      wr(8'h79, 8'ha5);
      repeat (40) @(negedge mclk) seen |= nv_write_en | reload_en;
      chk(seen, 0);
   endtask
   task t_refused(input logic [2:0] n);
      wr(8'h78, 8'ha5);
      @(posedge mclk) #1 chk({nv_write_en, program_fail_flag, program_count}, {2'b01, n});
   endtask
   task t_reload;
      wr(8'h79, 8'h5a);
      repeat (32) @(posedge mclk);
      #1 chk({reload_en, reload_data}, {1'b1, image_staged});
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 0;
      t_bad_keys;
      burn(0, 3'h1);
      burn(1, 3'h2);
      refresh_inhibit <= 0;
      burn(0, 3'h3);
      refresh_inhibit <= 1;
      // supply removed, settled through the synchroniser
      program_supply_ok <= 0;
      repeat (2) @(posedge mclk);
      t_refused(3'h3);
      program_supply_ok <= 1;
      repeat (2) @(posedge mclk);
      for (int i = 4; i < 7; i++) burn(0, 3'(i));
      t_refused(3'h6);
      t_reload;
      refresh_inhibit <= 0;
      @(posedge mclk) #1 chk(refresh_allow, 1'b1);
      summarize;
   end
   initial begin
      #50us;
      failures++;
      summarize;
   end
   task summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
endmodule
`default_nettype wire
